// ### core/ptp_stamp_pkg.sv
// Shared constants, types and register map for the timestamp port logic
package ptp_stamp_pkg;
    localparam int          STAMP_W      = 80;
    localparam int          SEC_W        = 48;
    localparam int          NS_W         = 32;
    localparam int          TAG_W        = 16;
    localparam int          LANE_W       = 2;
    localparam int          LANES        = 4;
    localparam int          FILL_W       = 7;
    localparam int          FIFO_DEPTH   = 8;
    localparam logic [1:0]  OP_NONE      = 2'h0;
    localparam logic [1:0]  OP_ONE_STEP  = 2'h1;
    localparam logic [1:0]  OP_TWO_STEP  = 2'h2;
    localparam logic [1:0]  OP_RESERVED  = 2'h3;
    // Wishbone word offsets (byte addresses)
    localparam logic [7:0]  ADR_CTRL     = 8'h00;
    localparam logic [7:0]  ADR_STATUS   = 8'h04;
    localparam logic [7:0]  ADR_TX_TAG   = 8'h08;
    localparam logic [7:0]  ADR_TX_NS    = 8'h0C;
    localparam logic [7:0]  ADR_TX_SECLO = 8'h10;
    localparam logic [7:0]  ADR_TX_SECHI = 8'h14;
    localparam logic [7:0]  ADR_FILL     = 8'h18;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          ST_OVF_BIT   = 0;
    localparam int          ST_TXV_BIT   = 1;

    typedef struct packed {
        logic [SEC_W-1:0] sec;
        logic [NS_W-1:0]  ns;
    } stamp_t;

    typedef struct packed {
        logic [TAG_W-1:0]  tag;
        logic [LANE_W-1:0] lane;
    } pend_t;

    typedef struct packed {
        logic              valid;
        logic [TAG_W-1:0]  tag;
        stamp_t            stamp;
        logic [LANE_W-1:0] lane;
    } tx_result_t;
endpackage : ptp_stamp_pkg

// ### core/ptp_tag_queue.sv
// Ordered queue of tags for frames awaiting their transmit timestamp
`timescale 1ns/1ps
`default_nettype none
module ptp_tag_queue #(
    parameter int DEPTH = ptp_stamp_pkg::FIFO_DEPTH
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 push_valid,
    output logic                      push_ready,
    input  wire ptp_stamp_pkg::pend_t push_data,
    output logic                      pop_valid,
    input  wire logic                 pop_ready,
    output ptp_stamp_pkg::pend_t      pop_data
);
    localparam int AW = $clog2(DEPTH);

    ptp_stamp_pkg::pend_t mem_q [DEPTH];
    logic [AW:0]          wr_q;
    logic [AW:0]          wr_d;
    logic [AW:0]          rd_q;
    logic [AW:0]          rd_d;
    logic                 do_push;
    logic                 do_pop;

    assign push_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign pop_valid  = wr_q != rd_q;
    assign pop_data   = mem_q[rd_q[AW-1:0]];
    assign do_push    = push_valid && push_ready;
    assign do_pop     = pop_valid && pop_ready;

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (do_push) begin
            wr_d = wr_q + (AW+1)'(1);
        end
        if (do_pop) begin
            rd_d = rd_q + (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage needs no reset; only slots between pointers are read
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem_q[wr_q[AW-1:0]] <= push_data;
        end
    end
endmodule // ptp_tag_queue
`default_nettype wire

// ### core/ptp_timestamp_port_logic.sv
// Transmit and receive timestamp port logic with a Wishbone register view
// Overview of operation
// RL1 - No-operation frames ignore the tag input
// RL2 - Stamped frames return their tag with timestamp
// RL3 - Valid strobe marks each presented transmit timestamp
// RL4 - Returned tag equals supplied tag bits 15:0
// RL5 - Transmit timestamp is 80 bits, timer format
// RL6 - Receive timestamp valid from start-of-packet cycle
// RL7 - Two-bit lane identity valid from start-of-packet
// RL8 - Report seven-bit fill per lane aligner
// RL9 - Client supplies one-step insertion and checksum offsets
// RL10 - Client supplies checksum request and receive stamp
// RL11 - Timer is 48 bits seconds, 32 nanoseconds
// RL12 - Op code: none, one-step, two-step
// RL13 - Op code three behaves as no operation
// RL14 - Tag, stamp, lane change together with valid
// RL15 - Timestamps return in frame acceptance order
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ptp_timestamp_port_logic #(
    parameter int DEPTH  = ptp_stamp_pkg::FIFO_DEPTH,
    parameter int FILL_W = ptp_stamp_pkg::FILL_W
) (
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_b,
    // Transmit frame request side
    input  wire logic                                    tx_frame_start,
    input  wire logic [1:0]                              tx_stamp_op_code,
    input  wire logic [ptp_stamp_pkg::TAG_W-1:0]         tx_tag_in,
    input  wire logic [ptp_stamp_pkg::TAG_W-1:0]         tx_stamp_offset_in,
    input  wire logic [ptp_stamp_pkg::TAG_W-1:0]         tx_csum_offset_in,
    input  wire logic                                    tx_csum_update_in,
    input  wire logic [63:0]                             tx_rx_stamp_in,
    input  wire logic [ptp_stamp_pkg::LANE_W-1:0]        tx_sop_lane,
    output logic                                         tx_frame_ready,
    // Capture plane crossing for transmit start of packet
    input  wire logic                                    tx_sop_capture,
    input  wire ptp_stamp_pkg::stamp_t                   timer_in,
    // Transmit result outputs, for one-step and two-step frames alike
    output logic                                         tx_stamp_valid,
    output logic [ptp_stamp_pkg::TAG_W-1:0]              tx_stamp_tag,
    output ptp_stamp_pkg::stamp_t                        tx_stamp,
    output logic [ptp_stamp_pkg::LANE_W-1:0]             tx_stamp_lane,
    // One-step insertion parameters toward the frame editor
    output logic [ptp_stamp_pkg::TAG_W-1:0]              ins_stamp_offset,
    output logic [ptp_stamp_pkg::TAG_W-1:0]              ins_csum_offset,
    output logic                                         ins_csum_update,
    output logic [63:0]                                  ins_rx_stamp,
    output logic                                         ins_enable,
    // Receive side
    input  wire logic                                    rx_sop,
    input  wire logic [ptp_stamp_pkg::LANE_W-1:0]        rx_sop_lane,
    input  wire logic [ptp_stamp_pkg::LANES*FILL_W-1:0]  rx_aligner_fill_in,
    output ptp_stamp_pkg::stamp_t                        rx_stamp,
    output logic [ptp_stamp_pkg::LANE_W-1:0]             rx_stamp_lane,
    output logic [ptp_stamp_pkg::LANES*FILL_W-1:0]       rx_aligner_fill,
    // Wishbone classic slave
    input  wire logic                                    wb_cyc_i,
    input  wire logic                                    wb_stb_i,
    input  wire logic                                    wb_we_i,
    input  wire logic [7:0]                              wb_adr_i,
    input  wire logic [3:0]                              wb_sel_i,
    input  wire logic [31:0]                             wb_dat_i,
    output logic [31:0]                                  wb_dat_o,
    output logic                                         wb_ack_o
);

    function automatic logic stamp_op(input logic [1:0] op);
        stamp_op = (op == ptp_stamp_pkg::OP_ONE_STEP) ||
                   (op == ptp_stamp_pkg::OP_TWO_STEP); // RL12 RL13
    endfunction

    ptp_stamp_pkg::pend_t      push_data;
    ptp_stamp_pkg::pend_t      pop_data;
    logic                      push_ready;
    logic                      pop_valid;
    logic                      push_valid;
    logic                      pop_ready;
    logic                      en;
    ptp_stamp_pkg::tx_result_t res_q;
    ptp_stamp_pkg::tx_result_t res_d;
    logic                      ovf_q;
    logic                      ovf_d;
    logic [31:0]               ctrl_q;
    logic [31:0]               ctrl_d;
    logic                      ack_q;
    logic                      ack_d;
    logic [31:0]               rdat_q;
    logic [31:0]               rdat_d;
    logic [ptp_stamp_pkg::TAG_W-1:0] ins_so_q;
    logic [ptp_stamp_pkg::TAG_W-1:0] ins_so_d;
    logic [ptp_stamp_pkg::TAG_W-1:0] ins_co_q;
    logic [ptp_stamp_pkg::TAG_W-1:0] ins_co_d;
    logic                      ins_cu_q;
    logic                      ins_cu_d;
    logic                      ins_en_q;
    logic                      ins_en_d;
    logic [63:0]               ins_rx_q;
    logic [63:0]               ins_rx_d;

    assign en         = ctrl_q[ptp_stamp_pkg::CTRL_EN_BIT];
    assign push_valid = tx_frame_start && en && stamp_op(tx_stamp_op_code); // RL1 RL13
    assign push_data  = '{tag: tx_tag_in, lane: tx_sop_lane}; // RL2
    // Frames that need no stamp never wait on the queue
    assign tx_frame_ready = push_ready || !stamp_op(tx_stamp_op_code) || !en;
    assign pop_ready  = tx_sop_capture;

    ptp_tag_queue #(
        .DEPTH(DEPTH)
    ) u_queue (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .push_valid(push_valid),
        .push_ready(push_ready),
        .push_data (push_data),
        .pop_valid (pop_valid),
        .pop_ready (pop_ready),
        .pop_data  (pop_data)
    ); // RL15

    always_comb begin
        res_d       = res_q;
        res_d.valid = 1'b0;
        ovf_d       = ovf_q;
        ins_so_d    = ins_so_q;
        ins_co_d    = ins_co_q;
        ins_cu_d    = ins_cu_q;
        ins_rx_d    = ins_rx_q;
        ins_en_d    = 1'b0;
        if (tx_sop_capture && pop_valid) begin
            res_d.valid = 1'b1; // RL3
            res_d.tag   = pop_data.tag[ptp_stamp_pkg::TAG_W-1:0]; // RL4 RL14
            res_d.stamp = timer_in; // RL5 RL11
            res_d.lane  = pop_data.lane; // RL7
        end else if (tx_sop_capture) begin
            ovf_d = 1'b1;
        end
        // Only an accepted frame may load new insertion parameters
        if (push_valid && push_ready && tx_stamp_op_code == ptp_stamp_pkg::OP_ONE_STEP) begin
            ins_en_d = 1'b1;
            ins_so_d = tx_stamp_offset_in; // RL9
            ins_co_d = tx_csum_offset_in; // RL9
            ins_cu_d = tx_csum_update_in; // RL10
            ins_rx_d = tx_rx_stamp_in; // RL10
        end
        ctrl_d = ctrl_q;
        ack_d  = 1'b0;
        rdat_d = rdat_q;
        if (wb_cyc_i && wb_stb_i && !ack_q) begin
            ack_d = 1'b1;
            if (wb_we_i) begin
                if (wb_adr_i == ptp_stamp_pkg::ADR_CTRL && wb_sel_i[0]) begin
                    ctrl_d[7:0] = wb_dat_i[7:0];
                end
                // Write one clears sticky underflow; a new event wins
                if (wb_adr_i == ptp_stamp_pkg::ADR_STATUS && wb_sel_i[0] &&
                    wb_dat_i[ptp_stamp_pkg::ST_OVF_BIT] && !(tx_sop_capture && !pop_valid)) begin
                    ovf_d = 1'b0;
                end
            end else begin
                case (wb_adr_i)
                    ptp_stamp_pkg::ADR_CTRL:     rdat_d = ctrl_q;
                    ptp_stamp_pkg::ADR_STATUS:   rdat_d = {30'h0, res_q.valid, ovf_q};
                    ptp_stamp_pkg::ADR_TX_TAG:   rdat_d = {14'h0, res_q.lane, res_q.tag};
                    ptp_stamp_pkg::ADR_TX_NS:    rdat_d = res_q.stamp.ns;
                    ptp_stamp_pkg::ADR_TX_SECLO: rdat_d = res_q.stamp.sec[31:0];
                    ptp_stamp_pkg::ADR_TX_SECHI: rdat_d = {16'h0, res_q.stamp.sec[47:32]};
                    ptp_stamp_pkg::ADR_FILL:     rdat_d = 32'(rx_aligner_fill_in);
                    default:                     rdat_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_q    <= '0;
            ovf_q    <= 1'b0;
            ctrl_q   <= ptp_stamp_pkg::CTRL_RST;
            ack_q    <= 1'b0;
            rdat_q   <= 32'h0000_0000;
            ins_so_q <= '0;
            ins_co_q <= '0;
            ins_cu_q <= 1'b0;
            ins_rx_q <= '0;
            ins_en_q <= 1'b0;
        end else begin
            res_q    <= res_d;
            ovf_q    <= ovf_d;
            ctrl_q   <= ctrl_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
            ins_so_q <= ins_so_d;
            ins_co_q <= ins_co_d;
            ins_cu_q <= ins_cu_d;
            ins_rx_q <= ins_rx_d;
            ins_en_q <= ins_en_d;
        end
    end

    assign tx_stamp_valid   = res_q.valid; // RL3 RL14
    assign tx_stamp_tag     = res_q.tag;
    assign tx_stamp         = res_q.stamp;
    assign tx_stamp_lane    = res_q.lane;
    assign ins_stamp_offset = ins_so_q;
    assign ins_csum_offset  = ins_co_q;
    assign ins_csum_update  = ins_cu_q;
    assign ins_rx_stamp     = ins_rx_q;
    assign ins_enable       = ins_en_q;
    assign wb_ack_o         = ack_q;
    assign wb_dat_o         = rdat_q;

    // Same-cycle validity needs a combinational path from the timer
    assign rx_stamp      = rx_sop ? timer_in : '0; // RL6 RL11
    assign rx_stamp_lane = rx_sop ? rx_sop_lane : '0; // RL7

    genvar gi;
    generate
        for (gi = 0; gi < ptp_stamp_pkg::LANES; gi++) begin : g_fill
            assign rx_aligner_fill[gi*FILL_W +: FILL_W] =
                rx_aligner_fill_in[gi*FILL_W +: FILL_W]; // RL8
        end
    endgenerate
endmodule // ptp_timestamp_port_logic
`default_nettype wire

// ### dv/ptp_stamp_monitor.sv
// Concurrent checks on the timestamp port logic ports
`timescale 1ns/1ps
`default_nettype none
module ptp_stamp_monitor #(
    parameter int FILL_W = ptp_stamp_pkg::FILL_W
) (
    input wire logic                      ref_clk,
    input wire logic                      rst_b,
    input wire logic                      tx_frame_start,
    input wire logic [1:0]                tx_stamp_op_code,
    input wire logic [15:0]               tx_stamp_offset_in,
    input wire logic                      tx_frame_ready,
    input wire logic                      tx_sop_capture,
    input wire ptp_stamp_pkg::stamp_t     timer_in,
    input wire logic                      tx_stamp_valid,
    input wire logic [15:0]               tx_stamp_tag,
    input wire ptp_stamp_pkg::stamp_t     tx_stamp,
    input wire logic [1:0]                tx_stamp_lane,
    input wire logic [15:0]               ins_stamp_offset,
    input wire logic                      ins_enable,
    input wire logic                      rx_sop,
    input wire logic [1:0]                rx_sop_lane,
    input wire logic [4*FILL_W-1:0]       rx_aligner_fill_in,
    input wire ptp_stamp_pkg::stamp_t     rx_stamp,
    input wire logic [1:0]                rx_stamp_lane,
    input wire logic [4*FILL_W-1:0]       rx_aligner_fill
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_valid_after_cap: assert property (tx_stamp_valid |-> $past(tx_sop_capture))
        else $error("stamp valid without capture");
    a_stamp_from_timer: assert property (tx_stamp_valid |-> tx_stamp == $past(timer_in))
        else $error("stamp differs from timer");
    a_sec_field_split: assert property (tx_stamp_valid |-> tx_stamp.sec == $past(timer_in[79:32]))
        else $error("seconds field misplaced");
    a_fields_hold: assert property (!tx_stamp_valid |-> $stable({tx_stamp_tag, tx_stamp, tx_stamp_lane}))
        else $error("result changed without valid");
    a_rx_stamp_now: assert property (rx_sop |-> rx_stamp == timer_in)
        else $error("rx stamp late");
    a_rx_lane_now: assert property (rx_sop |-> rx_stamp_lane == rx_sop_lane)
        else $error("rx lane late");
    a_fill_follows: assert property (rx_aligner_fill == rx_aligner_fill_in)
        else $error("fill level differs");
    a_no_op_ready: assert property (tx_stamp_op_code inside {2'h0, 2'h3} |-> tx_frame_ready)
        else $error("unstamped frame stalled");
    a_one_step_params: assert property (ins_enable |->
        $past(tx_frame_start && tx_frame_ready && tx_stamp_op_code == 2'h1)
        && ins_stamp_offset == $past(tx_stamp_offset_in))
        else $error("one-step parameters wrong");
    c_tx_valid: cover property (tx_stamp_valid);
    c_rx_sop: cover property (rx_sop);
    c_one_step: cover property (ins_enable);
    c_queue_stall: cover property (tx_frame_start && !tx_frame_ready);
endmodule // ptp_stamp_monitor
bind ptp_timestamp_port_logic ptp_stamp_monitor #(.FILL_W(FILL_W)) i_ptp_stamp_monitor (
    .ref_clk, .rst_b, .tx_frame_start, .tx_stamp_op_code, .tx_stamp_offset_in, .tx_frame_ready,
    .tx_sop_capture, .timer_in, .tx_stamp_valid, .tx_stamp_tag, .tx_stamp, .tx_stamp_lane,
    .ins_stamp_offset, .ins_enable, .rx_sop, .rx_sop_lane, .rx_aligner_fill_in, .rx_stamp,
    .rx_stamp_lane, .rx_aligner_fill);
`default_nettype wire

// ### dv/ptp_client_model.sv
// Client model offering frames with their stamp requests
`timescale 1ns/1ps
`default_nettype none
module ptp_client_model (
    input wire logic      ref_clk,
    input wire logic      tx_frame_ready,
    output logic          tx_frame_start,
    output logic [1:0]    tx_stamp_op_code,
    output logic [15:0]   tx_tag_in,
    output logic [15:0]   tx_stamp_offset_in,
    output logic [15:0]   tx_csum_offset_in,
    output logic          tx_csum_update_in,
    output logic [63:0]   tx_rx_stamp_in,
    output logic [1:0]    tx_sop_lane
);
    initial begin
        {tx_frame_start, tx_stamp_op_code, tx_tag_in, tx_sop_lane} = '0;
        {tx_stamp_offset_in, tx_csum_offset_in, tx_csum_update_in, tx_rx_stamp_in} = '0;
    end
    // Called just after a rising edge; frame held until ready seen or 40 edges pass
    task automatic send(input logic [1:0] op, input logic [15:0] tag, input logic [1:0] ln,
                        output logic ok);
        int n;
        n = 0;
        tx_frame_start <= 1'b1;
        tx_stamp_op_code <= op;
        tx_tag_in <= tag;
        tx_sop_lane <= ln;
        tx_stamp_offset_in <= {tag[7:0], 8'h2A};
        tx_csum_offset_in <= tag ^ 16'h0FF0;
        tx_csum_update_in <= tag[0];
        tx_rx_stamp_in <= {4{tag}};
        do begin
            @(posedge ref_clk);
            n++;
        end while (tx_frame_ready !== 1'b1 && n < 40);
        ok = (tx_frame_ready === 1'b1);
        tx_frame_start <= 1'b0;
        // Released tag and lane lines show no stale copy
        tx_tag_in <= ~tag;
        tx_sop_lane <= ~ln;
        @(posedge ref_clk);
    endtask
endmodule // ptp_client_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the timestamp port logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk, rst_b, tx_frame_start, tx_csum_update_in, tx_frame_ready, tx_sop_capture;
    logic [1:0] tx_stamp_op_code, tx_sop_lane, tx_stamp_lane, rx_sop_lane, rx_stamp_lane, op, ln;
    logic [15:0] tx_tag_in, tx_stamp_offset_in, tx_csum_offset_in, tx_stamp_tag, tag;
    logic [63:0] tx_rx_stamp_in;
    logic [27:0] rx_aligner_fill_in, rx_aligner_fill;
    logic tx_stamp_valid, rx_sop, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ok;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, v;
    logic [95:0] r;
    logic [17:0] e;
    logic [17:0] last;
    logic [15:0] ins_stamp_offset, ins_csum_offset, t;
    logic [63:0] ins_rx_stamp;
    logic ins_csum_update, ins_enable;
    logic [15:0] one_q[$];
    ptp_stamp_pkg::stamp_t timer_in, tx_stamp, rx_stamp;
    ptp_stamp_pkg::stamp_t stamp_q[$];
    logic [17:0] exp_q[$];
    int failures, checked, seed, i;
    ptp_timestamp_port_logic i_ptp_timestamp_port_logic (.ref_clk, .rst_b, .tx_frame_start,
        .tx_stamp_op_code, .tx_tag_in, .tx_stamp_offset_in, .tx_csum_offset_in,
        .tx_csum_update_in, .tx_rx_stamp_in, .tx_sop_lane, .tx_frame_ready, .tx_sop_capture,
        .timer_in, .tx_stamp_valid, .tx_stamp_tag, .tx_stamp, .tx_stamp_lane,
        .ins_stamp_offset, .ins_csum_offset, .ins_csum_update, .ins_rx_stamp,
        .ins_enable, .rx_sop, .rx_sop_lane, .rx_aligner_fill_in, .rx_stamp, .rx_stamp_lane,
        .rx_aligner_fill, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o);
    ptp_client_model i_ptp_client_model (.ref_clk, .tx_frame_ready, .tx_frame_start,
        .tx_stamp_op_code, .tx_tag_in, .tx_stamp_offset_in, .tx_csum_offset_in,
        .tx_csum_update_in, .tx_rx_stamp_in, .tx_sop_lane);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [79:0] seen, input logic [79:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t %h %h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            complete_run();
        end
        @(posedge ref_clk);
    endtask
    // Result watcher: oldest note against each presented stamp
    always @(negedge ref_clk) begin
        if (rst_b === 1'b1 && tx_stamp_valid === 1'b1) begin
            if (exp_q.size() == 0 || stamp_q.size() == 0) chk(1, 0);
            else begin
                e = exp_q.pop_front();
                chk(tx_stamp_tag, e[15:0]);
                chk(tx_stamp_lane, e[17:16]);
                chk(tx_stamp, stamp_q.pop_front());
            end
        end
        if (rst_b === 1'b1 && ins_enable === 1'b1) begin
            if (one_q.size() == 0) chk(1, 0);
            else begin
                t = one_q.pop_front();
                chk(ins_stamp_offset, {t[7:0], 8'h2A});
                chk(ins_csum_offset, t ^ 16'h0FF0);
                chk(ins_csum_update, t[0]);
                chk(ins_rx_stamp, {4{t}});
            end
        end
    end
    initial begin
        seed = 15031;
        {rst_b, tx_sop_capture, rx_sop, rx_sop_lane, rx_aligner_fill_in, timer_in} = '0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        wb(1'b0, ptp_stamp_pkg::ADR_CTRL, 32'h0, rd);
        chk(rd, ptp_stamp_pkg::CTRL_RST);
        wb(1'b1, ptp_stamp_pkg::ADR_CTRL, 32'h1, rd);
        wb(1'b0, 8'h3C, 32'h0, rd);
        chk(rd, 0);
        // Every op code four times, eight stamped frames filling the queue; a ninth two-step frame is refused
        for (i = 0; i < 17; i++) begin
            op = (i == 16) ? 2'h2 : i[1:0];
            v = $random(seed);
            tag = v[15:0];
            ln = v[17:16];
            if (i < 16 && (op == 2'h1 || op == 2'h2)) begin
                exp_q.push_back({ln, tag});
                last = {ln, tag};
            end
            if (i < 16 && op == 2'h1) one_q.push_back(tag);
            i_ptp_client_model.send(op, tag, ln, ok);
            if (i == 16) chk(ok, 0);
            else if (ok !== 1'b1) begin
                failures++;
                complete_run();
            end
        end
        // Back-to-back captures; the ninth finds the queue empty
        for (i = 0; i < 9; i++) begin
            r = {$random(seed), $random(seed), $random(seed)};
            timer_in <= r[79:0];
            if (i < 8) stamp_q.push_back(r[79:0]);
            tx_sop_capture <= 1'b1;
            @(posedge ref_clk);
        end
        tx_sop_capture <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(80'(exp_q.size()), 0);
        wb(1'b0, ptp_stamp_pkg::ADR_STATUS, 32'h0, rd);
        chk(rd[0], 1);
        chk(80'(one_q.size()), 0);
        wb(1'b0, ptp_stamp_pkg::ADR_TX_TAG, 32'h0, rd);
        chk(rd, {14'h0, last});
        wb(1'b1, ptp_stamp_pkg::ADR_STATUS, 32'h1, rd);
        wb(1'b0, ptp_stamp_pkg::ADR_STATUS, 32'h0, rd);
        chk(rd[0], 0);
        for (i = 0; i < 8; i++) begin
            r = {$random(seed), $random(seed), $random(seed)};
            v = $random(seed);
            timer_in <= r[79:0];
            rx_sop <= i[0];
            rx_sop_lane <= r[81:80];
            rx_aligner_fill_in <= v[27:0];
            @(negedge ref_clk);
            if (rx_sop) chk(rx_stamp, timer_in);
            if (rx_sop) chk(rx_stamp_lane, rx_sop_lane);
            chk(rx_aligner_fill, rx_aligner_fill_in);
            @(posedge ref_clk);
        end
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
